// ===== frsp_pkg.sv
// Constants and types for the flash row self-programming controller
package frsp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int          AXI_AW   = 14;
  localparam logic [11:0] IDX_CTL  = 12'h760;
  localparam logic [11:0] IDX_ADRL = 12'h762;
  localparam logic [11:0] IDX_ADRH = 12'h764;
  localparam logic [11:0] IDX_KEY  = 12'h766;
  localparam logic [11:0] IDX_PAGE = 12'h768;
  localparam logic [11:0] IDX_STAT = 12'h76a;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Control register fields and codes
  // ----------------------------------------------------------------
  localparam int          CTL_GO_BIT   = 15;
  localparam int          CTL_MODIFY_PERMIT_BIT_BIT = 14;
  localparam int          CTL_ERR_BIT  = 13;
  localparam int          OP_W         = 7;
  localparam logic [6:0]  OP_ERASE_ROW = 7'h41;
  localparam logic [6:0]  OP_PROG_ROW  = 7'h01;
  localparam int          STAT_DONE_BIT = 0;
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'haa;

  // ----------------------------------------------------------------
  // Array geometry and timing
  // ----------------------------------------------------------------
  localparam int ROW_INSTR      = 32;
  localparam int ROWS_PER_PANEL = 128;
  localparam int IDX_LSB        = 1;
  localparam int IDX_W          = 5;
  localparam int ROW_LSB        = 6;
  localparam int PANEL_LSB      = 13;
  localparam int OP_TIME_NS     = 2000000;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int OP_CYCLES_DEF  = OP_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    REG_NONE, REG_CTL, REG_ADRL, REG_ADRH, REG_KEY, REG_PAGE, REG_STAT
  } frsp_reg_t;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} frsp_key_t;

endpackage

// ===== frsp_ctrl.sv
// Flash row self-programming controller with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module frsp_ctrl import frsp_pkg::*; #(
  parameter int NUM_PANELS = 1,
  parameter int OP_CYCLES  = OP_CYCLES_DEF
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output      logic              wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output      logic              bvalid,
  input  wire logic              bready,
  output      logic [1:0]        bresp,
  input  wire logic              arvalid,
  output      logic              arready,
  input  wire logic [AXI_AW-1:0] araddr,
  output      logic              rvalid,
  input  wire logic              rready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  input  wire logic              tbl_req,
  input  wire logic              tbl_write,
  input  wire logic              tbl_high,
  input  wire logic              tbl_byte,
  input  wire logic [15:0]       tbl_ea,
  input  wire logic [15:0]       tbl_wdata,
  output      logic              tbl_done,
  output      logic [15:0]       tbl_rdata,
  input  wire logic              abort_rst_pin,
  output      logic              cpu_stall,
  output      logic              flash_done_flag,
  output      logic              fl_rd_en,
  output      logic [23:0]       fl_addr,
  input  wire logic [23:0]       fl_rd_data,
  output      logic              fl_erase,
  output      logic              fl_wr_en,
  output      logic [23:0]       fl_wr_data
);

  localparam int TMR_W = $clog2(OP_CYCLES + 1);

  typedef struct packed {
    logic s1, s2, s3, filt, prev;
    logic awready, aw_got, wready, w_got, bvalid, arready, rvalid;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic              t_ph, t_write, t_high, t_byte, t_odd;
    logic              tbl_done;
    logic [15:0]       tbl_rdata;
    logic              busy, modify_permit_bit, err, done, strm;
    logic [OP_W-1:0]   op;
    logic [15:0]       adr_lo;
    logic [7:0]        adr_hi, page;
    frsp_key_t         key;
    logic [TMR_W-1:0]  timer;
    logic [IDX_W-1:0]  widx;
    logic              fl_rd_en, fl_erase, fl_wr_en;
    logic [23:0]       fl_addr, fl_wr_data;
  } frsp_state_t;

  frsp_state_t s, n;
  logic [23:0] latch [NUM_PANELS*ROW_INSTR];
  logic [23:0] latch_rd;
  logic [23:0] wr_ptr;
  logic        abort_evt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic frsp_reg_t dec(input logic [AXI_AW-1:0] a);
    logic [11:0] idx;
    idx = a[AXI_AW-1:2];
    case (idx)
      IDX_CTL:  dec = REG_CTL;
      IDX_ADRL: dec = REG_ADRL;
      IDX_ADRH: dec = REG_ADRH;
      IDX_KEY:  dec = REG_KEY;
      IDX_PAGE: dec = REG_PAGE;
      IDX_STAT: dec = REG_STAT;
      default:  dec = REG_NONE;
    endcase
  endfunction

  function automatic logic [15:0] lanes(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    lanes = {st[1] ? d[15:8] : o[15:8], st[0] ? d[7:0] : o[7:0]};
  endfunction

  // Panel slot of a program address; address bits from PANEL_LSB up, modulo NUM_PANELS, select the panel
  function automatic int lat_idx(input logic [23:0] a);
    lat_idx = (int'(a[23:PANEL_LSB]) % NUM_PANELS) * ROW_INSTR
            + int'(a[IDX_LSB +: IDX_W]);
  endfunction

  // Odd-address high byte is the phantom byte: reads zero, writes ignored
  function automatic logic [23:0] wr_lane(input logic [23:0] o, input logic [15:0] d,
                                          input logic h, input logic b, input logic odd);
    wr_lane = o;
    if (h) begin
      if (!(b && odd)) wr_lane[23:16] = d[7:0];
    end else if (!b) begin
      wr_lane[15:0] = d;
    end else if (odd) begin
      wr_lane[15:8] = d[7:0];
    end else begin
      wr_lane[7:0] = d[7:0];
    end
  endfunction

  function automatic logic [15:0] rd_lane(input logic [23:0] w, input logic h,
                                          input logic b, input logic odd);
    if (h) rd_lane = (b && odd) ? 16'h0000 : {8'h00, w[23:16]};
    else if (!b) rd_lane = w[15:0];
    else rd_lane = {8'h00, odd ? w[15:8] : w[7:0]};
  endfunction

  assign wr_ptr    = {s.page, tbl_ea};
  assign latch_rd  = latch[lat_idx({s.adr_hi, s.adr_lo[15:ROW_LSB], s.widx, 1'b0})];
  assign abort_evt = s.filt && !s.prev;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    frsp_reg_t  wsel;
    frsp_reg_t  rsel;
    logic [31:0] wd;
    logic        do_wr;
    n = s;
    wsel = dec(s.aw_addr);
    rsel = dec(araddr);
    wd = s.wdata;
    do_wr = s.aw_got && s.w_got && !s.bvalid;
    n.tbl_done = 1'b0;
    n.fl_rd_en = 1'b0;
    n.fl_erase = 1'b0;
    n.fl_wr_en = 1'b0;

    // Reset-event pin: three stages, change accepted when last two agree
    n.s1 = abort_rst_pin;
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (s.s2 == s.s3) n.filt = s.s3;
    n.prev = s.filt;

    // Table access; the core is stalled while an operation runs
    n.t_ph = tbl_req && !s.busy;
    if (tbl_req && !s.busy) begin
      n.t_write = tbl_write;
      n.t_high  = tbl_high;
      n.t_byte  = tbl_byte;
      n.t_odd   = tbl_ea[0];
      n.adr_lo  = tbl_ea;
      n.adr_hi  = s.page;
      n.key     = KEY_IDLE;
      if (!tbl_write) begin
        n.fl_rd_en = 1'b1;
        n.fl_addr  = wr_ptr;
      end
    end
    if (s.t_ph) begin
      n.tbl_done = 1'b1;
      if (!s.t_write) n.tbl_rdata = rd_lane(fl_rd_data, s.t_high, s.t_byte, s.t_odd);
    end

    // AXI write channels, taken in either order
    if (awvalid && s.awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (s.bvalid && bready) n.bvalid = 1'b0;
    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      n.key    = KEY_IDLE;
      case (wsel)
        REG_CTL: begin
          if (!s.busy) begin
            if (s.wstrb[0]) n.op = wd[OP_W-1:0];
            if (s.wstrb[1]) begin
              n.modify_permit_bit = wd[CTL_MODIFY_PERMIT_BIT_BIT];
              if (!wd[CTL_ERR_BIT]) n.err = 1'b0;
              if (wd[CTL_GO_BIT] && wd[CTL_MODIFY_PERMIT_BIT_BIT] && s.key == KEY_ARMED
                  && (n.op == OP_ERASE_ROW || n.op == OP_PROG_ROW)) begin
                n.busy  = 1'b1;
                n.timer = TMR_W'(OP_CYCLES - 1);
                n.widx  = '0;
                n.strm  = (n.op == OP_PROG_ROW);
                if (n.op == OP_ERASE_ROW) begin
                  n.fl_erase = 1'b1;
                  n.fl_addr  = {s.adr_hi, s.adr_lo[15:ROW_LSB], {ROW_LSB{1'b0}}};
                end
              end
            end
          end
        end
        REG_ADRL: if (!s.busy) n.adr_lo = lanes(s.adr_lo, wd, s.wstrb);
        REG_ADRH: if (!s.busy && s.wstrb[0]) n.adr_hi = wd[7:0];
        REG_PAGE: if (s.wstrb[0]) n.page = wd[7:0];
        REG_STAT: if (s.wstrb[0] && wd[STAT_DONE_BIT]) n.done = 1'b0;
        REG_KEY: begin
          if (s.wstrb[0] && wd[7:0] == KEY_FIRST && s.key == KEY_IDLE)
            n.key = KEY_GOT1;
          else if (s.wstrb[0] && wd[7:0] == KEY_SECOND && s.key == KEY_GOT1)
            n.key = KEY_ARMED;
        end
        default: ;
      endcase
    end

    // AXI read channel; the key register reads as zero
    if (s.rvalid && rready) n.rvalid = 1'b0;
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.key    = KEY_IDLE;
      n.rresp  = (rsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (rsel)
        REG_CTL:  n.rdata = {16'h0000, s.busy, s.modify_permit_bit, s.err, 6'h00, s.op};
        REG_ADRL: n.rdata = {16'h0000, s.adr_lo};
        REG_ADRH: n.rdata = {24'h000000, s.adr_hi};
        REG_PAGE: n.rdata = {24'h000000, s.page};
        REG_STAT: n.rdata = {31'h00000000, s.done};
        default:  n.rdata = 32'h00000000;
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;

    // Row operation: a program streams the whole row while the cell time counts down
    if (s.busy) begin
      if (s.strm) begin
        n.fl_wr_en   = 1'b1;
        n.fl_addr    = {s.adr_hi, s.adr_lo[15:ROW_LSB], s.widx, 1'b0};
        n.fl_wr_data = latch_rd;
        n.widx       = s.widx + 1'b1;
        if (s.widx == IDX_W'(ROW_INSTR - 1)) n.strm = 1'b0;
      end
      if (abort_evt) begin
        n.busy     = 1'b0;
        n.strm     = 1'b0;
        n.fl_wr_en = 1'b0;
        n.err      = 1'b1;
      end else if (s.timer == '0) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.timer = s.timer - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register and write latches
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s     <= '0;
      s.key <= KEY_IDLE;
    end else begin
      s <= n;
    end
  end

  // Latches only, never the array, on a table write
  always_ff @(posedge sys_clk) begin
    if (tbl_req && tbl_write && !s.busy)
      latch[lat_idx(wr_ptr)] <= wr_lane(latch[lat_idx(wr_ptr)], tbl_wdata,
                                        tbl_high, tbl_byte, tbl_ea[0]);
  end

  assign awready         = s.awready;
  assign wready          = s.wready;
  assign bvalid          = s.bvalid;
  assign bresp           = s.bresp;
  assign arready         = s.arready;
  assign rvalid          = s.rvalid;
  assign rdata           = s.rdata;
  assign rresp           = s.rresp;
  assign tbl_done        = s.tbl_done;
  assign tbl_rdata       = s.tbl_rdata;
  assign cpu_stall       = s.busy;
  assign flash_done_flag = s.done;
  assign fl_rd_en        = s.fl_rd_en;
  assign fl_addr         = s.fl_addr;
  assign fl_erase        = s.fl_erase;
  assign fl_wr_en        = s.fl_wr_en;
  assign fl_wr_data      = s.fl_wr_data;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int op_cnt;
  int wr_cnt;
  always_ff @(posedge sys_clk) begin
    if (!resetn || !s.busy) begin
      op_cnt <= 0;
      wr_cnt <= 0;
    end else begin
      op_cnt <= op_cnt + 1;
      wr_cnt <= wr_cnt + (s.fl_wr_en ? 1 : 0);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence seq_tbl_access;
    tbl_req && !cpu_stall ##2 tbl_done;
  endsequence

  sequence seq_op_end;
    $fell(cpu_stall) && flash_done_flag;
  endsequence

  chk_tbl_two_cycle: assert property (tbl_req && !cpu_stall |-> seq_tbl_access)
    else $error("table access did not finish in two cycles");
  chk_addr_capture: assert property (tbl_req && !cpu_stall |=>
    {s.adr_hi, s.adr_lo} == {$past(s.page), $past(tbl_ea)})
    else $error("address registers did not capture table address");
  chk_op_length: assert property (seq_op_end |-> op_cnt == OP_CYCLES)
    else $error("operation length wrong");
  chk_row_burst: assert property ($fell(cpu_stall) && flash_done_flag &&
    s.op == OP_PROG_ROW |-> wr_cnt == ROW_INSTR)
    else $error("program did not write a whole row");
  chk_go_keyed: assert property ($rose(cpu_stall) |-> $past(s.key) == KEY_ARMED
    && s.modify_permit_bit)
    else $error("operation started without keys or permit");
  chk_stall_done: assert property ($fell(cpu_stall) |-> flash_done_flag
    || $rose(s.err))
    else $error("stall released without completion");
  chk_done_sticky: assert property (flash_done_flag |=> flash_done_flag
    || $rose(bvalid))
    else $error("done flag dropped without software");
  chk_erase_row: assert property (fl_erase |-> fl_addr[ROW_LSB-1:0] == '0
    && cpu_stall)
    else $error("erase not row aligned");
  chk_abort_keep: assert property (cpu_stall && abort_evt |=> !cpu_stall && s.err
    && $stable(s.adr_lo))
    else $error("interrupted operation not flagged");

endmodule

// ===== frsp_flash_model.sv
// Behavioural flash array facing the controller's array port
`timescale 1ns/100ps
module frsp_flash_model (
  input  wire logic        sys_clk,
  input  wire logic        fl_rd_en,
  input  wire logic [23:0] fl_addr,
  output      logic [23:0] fl_rd_data,
  input  wire logic        fl_erase,
  input  wire logic        fl_wr_en,
  input  wire logic [23:0] fl_wr_data,
  output      int          wr_count
);
  // Words never written read back as erased
  logic [23:0] mem [int];
  logic [23:0] junk = 24'h5a5a5a;
  int          row_base;

  initial begin
    wr_count = 0;
  end

  // Data stands only while the read strobe is up; otherwise it churns so stale use shows
  always @(fl_rd_en or fl_addr or junk) begin
    if (fl_rd_en && mem.exists(fl_addr[23:1])) begin
      fl_rd_data = mem[fl_addr[23:1]];
    end else if (fl_rd_en) begin
      fl_rd_data = 24'hffffff;
    end else begin
      fl_rd_data = junk;
    end
  end

  always @(posedge sys_clk) begin
    junk <= ~junk;
    if (fl_erase) begin
      row_base = {fl_addr[23:6], 5'h00};
      for (int i = 0; i < 32; i++) mem.delete(row_base + i);
    end
    if (fl_wr_en) begin
      mem[fl_addr[23:1]] = fl_wr_data;
      wr_count <= wr_count + 1;
    end
  end
endmodule

// ===== frsp_ctrl_tb_top.sv
// Self-checking bench for the flash row self-programming controller
`timescale 1ns/100ps
module frsp_ctrl_tb_top import frsp_pkg::*; ;
  localparam int          OPC  = 64;
  localparam logic [15:0] BASE = 16'h0040;
  logic              sys_clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, abort_rst_pin;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rdv;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rsp;
  logic              tbl_req, tbl_write, tbl_high, tbl_byte, tbl_done;
  logic [15:0]       tbl_ea, tbl_wdata, tbl_rdata, tv;
  logic              cpu_stall, flash_done_flag, fl_rd_en, fl_erase, fl_wr_en;
  logic [23:0]       fl_addr, fl_rd_data, fl_wr_data;
  int                err_total, num_checks, stall_mark, fl_writes;
  int                stall_cnt = 0;
  logic [11:0]       reg_idx [6];

  frsp_ctrl #(.NUM_PANELS(1), .OP_CYCLES(OPC)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .tbl_req(tbl_req), .tbl_write(tbl_write),
    .tbl_high(tbl_high), .tbl_byte(tbl_byte), .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata),
    .tbl_done(tbl_done), .tbl_rdata(tbl_rdata), .abort_rst_pin(abort_rst_pin),
    .cpu_stall(cpu_stall), .flash_done_flag(flash_done_flag), .fl_rd_en(fl_rd_en),
    .fl_addr(fl_addr), .fl_rd_data(fl_rd_data), .fl_erase(fl_erase),
    .fl_wr_en(fl_wr_en), .fl_wr_data(fl_wr_data));

  frsp_flash_model i_flash (
    .sys_clk(sys_clk), .fl_rd_en(fl_rd_en), .fl_addr(fl_addr), .fl_rd_data(fl_rd_data),
    .fl_erase(fl_erase), .fl_wr_en(fl_wr_en), .fl_wr_data(fl_wr_data),
    .wr_count(fl_writes));

  // ----------------------------------------------------------------
  // Clock, stall monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (cpu_stall === 1'b1) stall_cnt <= stall_cnt + 1;
  end

  // Whole run is well under a thousand cycles; this leaves ample margin
  initial begin
    #(20000 * 50);
    err_total++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Response ready stays up between transfers; only the watchdog ends a wait
  task automatic axi_wr(input logic [11:0] idx, input logic [31:0] d, output logic [1:0] r);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(idx, d, r);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic rchk(input string what, input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk(what, exp, d);
  endtask

  task automatic tbl(input logic w, h, b, input logic [15:0] ea, wd, output logic [15:0] v);
    tbl_req   <= 1'b1;
    tbl_write <= w;
    tbl_high  <= h;
    tbl_byte  <= b;
    tbl_ea    <= ea;
    tbl_wdata <= wd;
    @(posedge sys_clk);
    tbl_req <= 1'b0;
    @(posedge sys_clk);
    chk("tbl_done early", 32'h0, {31'h0, tbl_done});
    @(posedge sys_clk);
    chk("tbl_done", 32'h1, {31'h0, tbl_done});
    v = tbl_rdata;
  endtask

  task automatic start_op(input logic [31:0] ctl_v);
    wr(IDX_KEY, {24'h0, KEY_FIRST});
    wr(IDX_KEY, {24'h0, KEY_SECOND});
    stall_mark = stall_cnt;
    wr(IDX_CTL, ctl_v);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (cpu_stall !== 1'b0 && n < 4 * OPC) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, abort_rst_pin} = '0;
    {tbl_req, tbl_write, tbl_high, tbl_byte, tbl_ea, tbl_wdata} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    err_total = 0;
    num_checks = 0;
    reg_idx = '{IDX_CTL, IDX_ADRL, IDX_ADRH, IDX_KEY, IDX_PAGE, IDX_STAT};
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    foreach (reg_idx[k]) rchk("reset value", reg_idx[k], 32'h0);
    axi_wr(12'h7ff, 32'h1, rsp);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rd(12'h7ff, rdv, rsp);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped rdata", 32'h0, rdv);
    wr(IDX_KEY, 32'h55);
    rchk("key readback", IDX_KEY, 32'h0);
    // Fill one row of latches, low then high per word, ascending
    wr(IDX_PAGE, 32'h02);
    for (int i = 0; i < 32; i++) begin
      tbl(1'b1, 1'b0, 1'b0, 16'(BASE + 2 * i), 16'(16'h3c00 + i), tv);
      tbl(1'b1, 1'b1, 1'b0, 16'(BASE + 2 * i), {8'hee, 8'(64 + i)}, tv);
    end
    rchk("addr low", IDX_ADRL, 32'(BASE + 62));
    rchk("addr high", IDX_ADRH, 32'h02);
    // Byte lanes: odd low byte of word 0 replaced, phantom high byte ignored
    tbl(1'b1, 1'b0, 1'b1, 16'(BASE + 1), 16'hffc3, tv);
    tbl(1'b1, 1'b1, 1'b1, 16'(BASE + 1), 16'h0077, tv);
    tbl(1'b0, 1'b0, 1'b0, BASE, 16'h0, tv);
    chk("array before program", 32'hffff, {16'h0, tv});
    // Starts that must be refused
    start_op(32'h8001);
    chk("stall without permit", 32'h0, {31'h0, cpu_stall});
    wr(IDX_KEY, 32'h55);
    rchk("page", IDX_PAGE, 32'h02);
    wr(IDX_KEY, 32'haa);
    wr(IDX_CTL, 32'hc001);
    chk("stall broken unlock", 32'h0, {31'h0, cpu_stall});
    wr(IDX_KEY, 32'haa);
    wr(IDX_KEY, 32'h55);
    wr(IDX_CTL, 32'hc001);
    chk("stall keys reversed", 32'h0, {31'h0, cpu_stall});
    // Program the row
    start_op(32'hc001);
    chk("stall running", 32'h1, {31'h0, cpu_stall});
    rchk("go set", IDX_CTL, 32'hc001);
    wr(IDX_CTL, 32'h4001);
    rchk("go held", IDX_CTL, 32'hc001);
    wait_idle();
    chk("program stall length", OPC, stall_cnt - stall_mark);
    rchk("go cleared", IDX_CTL, 32'h4001);
    chk("done flag", 32'h1, {31'h0, flash_done_flag});
    chk("array writes", 32'd32, fl_writes);
    for (int i = 0; i < 32; i++) begin
      tbl(1'b0, 1'b0, 1'b0, 16'(BASE + 2 * i), 16'h0, tv);
      chk("low word", (i == 0) ? 32'hc300 : 32'(16'h3c00 + i), {16'h0, tv});
      tbl(1'b0, 1'b1, 1'b0, 16'(BASE + 2 * i), 16'h0, tv);
      chk("high byte", 32'(64 + i), {16'h0, tv});
    end
    tbl(1'b0, 1'b0, 1'b1, 16'(BASE + 1), 16'h0, tv);
    chk("low odd byte", 32'hc3, {16'h0, tv});
    tbl(1'b0, 1'b1, 1'b1, 16'(BASE + 1), 16'h0, tv);
    chk("high odd byte", 32'h0, {16'h0, tv});
    rchk("status done", IDX_STAT, 32'h1);
    wr(IDX_STAT, 32'h1);
    chk("done cleared", 32'h0, {31'h0, flash_done_flag});
    // Erase the row through directly written address registers
    wr(IDX_ADRL, 32'(BASE + 16'h10));
    wr(IDX_ADRH, 32'h02);
    start_op(32'hc041);
    wait_idle();
    chk("erase stall length", OPC, stall_cnt - stall_mark);
    tbl(1'b0, 1'b0, 1'b0, 16'(BASE + 62), 16'h0, tv);
    chk("erased low", 32'hffff, {16'h0, tv});
    tbl(1'b0, 1'b1, 1'b0, BASE, 16'h0, tv);
    chk("erased high", 32'hff, {16'h0, tv});
    // Reset event in mid-operation
    wr(IDX_STAT, 32'h1);
    wr(IDX_ADRL, 32'(BASE));
    start_op(32'hc001);
    abort_rst_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    abort_rst_pin <= 1'b0;
    wait_idle();
    chk("aborted early", 32'h1, {31'h0, (stall_cnt - stall_mark) < 12});
    rd(IDX_CTL, rdv, rsp);
    chk("go and error", 32'h1, {30'h0, rdv[CTL_GO_BIT], rdv[CTL_ERR_BIT]});
    chk("no done on abort", 32'h0, {31'h0, flash_done_flag});
    rchk("address kept", IDX_ADRL, 32'(BASE));
    report_and_stop();
  end
endmodule
